// >>> tlf_defines.vh
// Register offsets, field positions, reset values and timing counts
`ifndef TLF_DEFINES_VH
`define TLF_DEFINES_VH
`define TLF_OFF_LIMITS     12'h01c
`define TLF_OFF_SAMPLE     12'h020
`define TLF_OFF_FLAGS      12'h024
`define TLF_OFF_FLAG_SET   12'h028
`define TLF_OFF_FLAG_CLR   12'h02c
`define TLF_OFF_CTRL       12'h030
`define TLF_WAKE_BIT       16
`define TLF_UPPER_RESET    8'hff
`define TLF_LOWER_RESET    8'h00
`define TLF_FLAG_HIGH      31
`define TLF_FLAG_LOW       30
`define TLF_FLAG_SAMPLE    29
`define TLF_FLAG_MASK      32'he35ff0ff
`define TLF_SUPPLY_MASK    32'h0000f0ff
`define TLF_HOLD_MS        250
`define TLF_CLK_KHZ        25000
`define TLF_HOLD_CYCLES    (`TLF_HOLD_MS * `TLF_CLK_KHZ)
`endif

// >>> tlf_thermal_flags.v
// Thermal limit comparison and event flag register block on APB
// What this block does
// RULE1: Bit 16 of the limits register, reset 0, enables thermal wake from hibernate.
// RULE2: Upper limit in bits 15:8, reset 0xff; a sample at or above it sets flag 31.
// RULE3: Lower limit in bits 7:0, reset 0x00; a sample at or below it sets flag 30.
// RULE4: A limit written during a measurement takes effect once it finishes.
// RULE5: The last sample reads at 0x020 bits 7:0 and changes independent of reads.
// RULE6: After a thermal flag is raised the sample is frozen for 250 ms.
// RULE7: Software outside a thermal interrupt rereads until two reads agree.
// RULE8: Flags read at 0x024, implemented bits reset 0, reserved bits zero.
// RULE9: Each supply channel sets a rise flag on a rising edge, fall on falling.
// RULE10: Flags 17 and 16 report current-limit events and are internal only.
// RULE11: Writing ones to 0x028 sets the matching flags; zeros do nothing.
// RULE12: Writing ones to 0x02c clears flags; with read-clear on, reading it clears.
// RULE13: Every newly captured sample sets flag 29.
`timescale 1ns/1ps
`default_nettype none
`include "tlf_defines.vh"

module tlf_thermal_flags #(
  parameter [31:0] HOLD_CYCLES = `TLF_HOLD_CYCLES
) (
  input  wire        ref_clk,        // Register clock, 25 MHz
  input  wire        rst_n,          // Async reset, active low
  input  wire        psel,           // APB select
  input  wire        penable,        // APB access phase
  input  wire        pwrite,         // APB write
  input  wire [11:0] paddr,          // APB byte address
  input  wire [31:0] pwdata,         // APB write data
  output wire        pready,         // APB ready
  output reg  [31:0] prdata,         // APB read data
  output wire        pslverr,        // APB error
  input  wire        sample_valid,   // New sample pulse, same clock
  input  wire [7:0]  sample_value,   // Sample value with sample_valid
  input  wire        thermal_measure_in_progress, // Measurement busy
  input  wire [5:0]  supply_level,   // Supply monitor levels, async
  input  wire        low_side_current_limit,  // Current limit pulse
  input  wire        high_side_current_limit, // Current limit pulse
  input  wire        hibernate_state,         // Part is in hibernate
  output reg         thermal_wake,   // Wake request from hibernate
  output reg         deep_sleep_thermal_wake_enable // Wake enable bit
);

  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  reg [1:0] rst_sync;
  wire      rst_int_n = rst_sync[1];
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire rd       = access & ~pwrite;
  wire a_limits = (paddr == `TLF_OFF_LIMITS);
  wire a_sample = (paddr == `TLF_OFF_SAMPLE);
  wire a_flags  = (paddr == `TLF_OFF_FLAGS);
  wire a_set    = (paddr == `TLF_OFF_FLAG_SET);
  wire a_clr    = (paddr == `TLF_OFF_FLAG_CLR);
  wire a_ctrl   = (paddr == `TLF_OFF_CTRL);
  wire mapped   = a_limits | a_sample | a_flags | a_set | a_clr | a_ctrl;
  // Zero wait states: every access ends in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // ------------------------------------------------------------
  // Limits, with deferral during a measurement
  // ------------------------------------------------------------
  reg [7:0] thermal_upper_limit;
  reg [7:0] thermal_lower_limit;
  reg [7:0] pend_upper;
  reg [7:0] pend_lower;
  reg       pend_valid;
  reg       read_clear_enable;
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      thermal_upper_limit            <= `TLF_UPPER_RESET;
      thermal_lower_limit            <= `TLF_LOWER_RESET;
      pend_upper                     <= `TLF_UPPER_RESET;
      pend_lower                     <= `TLF_LOWER_RESET;
      pend_valid                     <= 1'b0;
      deep_sleep_thermal_wake_enable <= 1'b0;
      read_clear_enable              <= 1'b0;
    end else begin
      if (wr && a_ctrl)
        read_clear_enable <= pwdata[0];
      if (wr && a_limits) begin
        deep_sleep_thermal_wake_enable <= pwdata[`TLF_WAKE_BIT]; // RULE1
        if (thermal_measure_in_progress) begin
          pend_upper <= pwdata[15:8]; // RULE4
          pend_lower <= pwdata[7:0];
          pend_valid <= 1'b1;
        end else begin
          thermal_upper_limit <= pwdata[15:8];
          thermal_lower_limit <= pwdata[7:0];
          pend_valid          <= 1'b0;
        end
      end else if (pend_valid && !thermal_measure_in_progress) begin
        thermal_upper_limit <= pend_upper; // RULE4
        thermal_lower_limit <= pend_lower;
        pend_valid          <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Sample capture and hold window
  // ------------------------------------------------------------
  reg [7:0]  sample;
  reg [31:0] hold_cnt;
  wire       holding = (hold_cnt != 32'h0);
  wire       take    = sample_valid & ~holding; // RULE6
  wire       hit_hi  = take & (sample_value >= thermal_upper_limit); // RULE2
  wire       hit_lo  = take & (sample_value <= thermal_lower_limit); // RULE3
  wire       sw_temp = wr & a_set & (|pwdata[31:29]);
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      sample   <= 8'h00;
      hold_cnt <= 32'h0;
    end else begin
      if (take)
        sample <= sample_value; // RULE5
      // Any thermal flag restarts the freeze so one read is consistent
      if (take || sw_temp)
        hold_cnt <= HOLD_CYCLES; // RULE6
      else if (holding)
        hold_cnt <= hold_cnt - 32'h1;
    end
  end

  // ------------------------------------------------------------
  // Supply monitor edge detect, one synchroniser per channel
  // ------------------------------------------------------------
  // Supply order: 0 analog, 1 alt analog, 2 digital, 3 io, 4 backup, 5 flash
  wire [5:0] rise;
  wire [5:0] fall;

  tlf_supply_edge u_edge_analog (
    .ref_clk   (ref_clk),
    .rst_int_n (rst_int_n),
    .level_in  (supply_level[0]),
    .rise      (rise[0]),
    .fall      (fall[0])
  );

  tlf_supply_edge u_edge_alt_analog (
    .ref_clk   (ref_clk),
    .rst_int_n (rst_int_n),
    .level_in  (supply_level[1]),
    .rise      (rise[1]),
    .fall      (fall[1])
  );

  tlf_supply_edge u_edge_digital (
    .ref_clk   (ref_clk),
    .rst_int_n (rst_int_n),
    .level_in  (supply_level[2]),
    .rise      (rise[2]),
    .fall      (fall[2])
  );

  tlf_supply_edge u_edge_io (
    .ref_clk   (ref_clk),
    .rst_int_n (rst_int_n),
    .level_in  (supply_level[3]),
    .rise      (rise[3]),
    .fall      (fall[3])
  );

  tlf_supply_edge u_edge_backup (
    .ref_clk   (ref_clk),
    .rst_int_n (rst_int_n),
    .level_in  (supply_level[4]),
    .rise      (rise[4]),
    .fall      (fall[4])
  );

  tlf_supply_edge u_edge_flash (
    .ref_clk   (ref_clk),
    .rst_int_n (rst_int_n),
    .level_in  (supply_level[5]),
    .rise      (rise[5]),
    .fall      (fall[5])
  );

  // ------------------------------------------------------------
  // Hardware set sources, grouped by field
  // ------------------------------------------------------------
  wire [2:0]  thermal_set;
  wire [1:0]  current_set;
  wire [3:0]  upper_supply_set;
  wire [7:0]  lower_supply_set;
  wire [31:0] hw_set;
  assign thermal_set      = {hit_hi, hit_lo, take}; // RULE13
  assign current_set      = {low_side_current_limit,
                             high_side_current_limit}; // RULE10
  assign upper_supply_set = {rise[5], fall[5], rise[4], fall[4]}; // RULE9
  assign lower_supply_set = {rise[3], fall[3], rise[2], fall[2],
                             rise[1], fall[1], rise[0], fall[0]}; // RULE9
  assign hw_set           = {thermal_set, 11'h000, current_set,
                             upper_supply_set, 4'h0, lower_supply_set};

  // ------------------------------------------------------------
  // Event flags: set wins over clear
  // ------------------------------------------------------------
  reg  [31:0] flags;
  wire [31:0] sw_set = (wr && a_set) ? pwdata : 32'h0; // RULE11
  wire [31:0] sw_clr = (wr && a_clr) ? pwdata :
                       (rd && a_clr && read_clear_enable) ? 32'hffffffff :
                       32'h0; // RULE12
  wire [31:0] next_flags = ((flags & ~sw_clr) | hw_set | sw_set)
                           & `TLF_FLAG_MASK; // RULE8
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n)
      flags <= 32'h0; // RULE8
    else
      flags <= next_flags;
  end

  // ------------------------------------------------------------
  // Wake request
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n)
      thermal_wake <= 1'b0;
    else
      thermal_wake <= hibernate_state & deep_sleep_thermal_wake_enable &
                      (flags[`TLF_FLAG_HIGH] | flags[`TLF_FLAG_LOW]); // RULE1
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Loaded in the setup cycle, so it stands through the access phase
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0;
    case (paddr)
      `TLF_OFF_LIMITS:
        next_rdata = {15'h0, deep_sleep_thermal_wake_enable,
                      thermal_upper_limit, thermal_lower_limit};
      `TLF_OFF_SAMPLE:   next_rdata = {24'h0, sample}; // RULE5
      `TLF_OFF_FLAGS:    next_rdata = flags; // RULE8
      `TLF_OFF_FLAG_CLR: next_rdata = flags; // RULE12
      `TLF_OFF_CTRL:     next_rdata = {31'h0, read_clear_enable};
      default:           next_rdata = 32'h0;
    endcase
  end

  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= next_rdata;
  end

endmodule // tlf_thermal_flags

// ------------------------------------------------------------
// One supply channel: three-stage synchroniser and edge pulses
// ------------------------------------------------------------
module tlf_supply_edge #(
  parameter [0:0] IDLE_LEVEL = 1'b0
) (
  input  wire ref_clk,   // Register clock
  input  wire rst_int_n, // Synchronised reset, active low
  input  wire level_in,  // Supply level, asynchronous
  output wire rise,      // Pulse on a settled rising edge
  output wire fall       // Pulse on a settled falling edge
);

  reg  sync1;
  reg  sync2;
  reg  sync3;
  reg  level;
  wire next_level;

  // A change counts only once the last two stages agree
  assign next_level = (sync2 & sync3) | (level & (sync2 | sync3));

  // Reset to the idle level so no false edge follows reset
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      sync1 <= IDLE_LEVEL;
      sync2 <= IDLE_LEVEL;
      sync3 <= IDLE_LEVEL;
      level <= IDLE_LEVEL;
    end else begin
      sync1 <= level_in;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= next_level;
    end
  end

  assign rise = next_level & ~level; // RULE9
  assign fall = ~next_level & level; // RULE9

endmodule // tlf_supply_edge
`default_nettype wire

// >>> tlf_checker_assertions.sv
// Bus and wake-request properties of the thermal limit flag block
`timescale 1ns/1ps
`default_nettype none
`include "tlf_defines.vh"
module tlf_checker (
  input wire logic        ref_clk,         // Clock
  input wire logic        rst_n,           // Reset, active low
  input wire logic        psel,            // Select
  input wire logic        penable,         // Access phase
  input wire logic        pwrite,          // Write
  input wire logic [11:0] paddr,           // Address
  input wire logic [31:0] pwdata,          // Write data
  input wire logic        pready,          // Ready
  input wire logic [31:0] prdata,          // Read data
  input wire logic        pslverr,         // Error
  input wire logic        hibernate_state, // Hibernate
  input wire logic        thermal_wake,    // Wake request
  input wire logic        deep_sleep_thermal_wake_enable // Wake enable
);
  // ---------------------------------------------------------
  // Properties
  // ---------------------------------------------------------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  sequence s_limit_write;
    acc && pwrite && paddr == 12'h01c;
  endsequence
  sequence s_read(logic [11:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  a_wake_enable_mirror: assert property (s_limit_write |=>
    deep_sleep_thermal_wake_enable == $past(pwdata[16])) else $error("wake en");
  a_wake_needs_enable: assert property (thermal_wake |->
    $past(hibernate_state) && $past(deep_sleep_thermal_wake_enable))
    else $error("wake without enable");
  a_wake_drop: assert property (!hibernate_state |=> !thermal_wake)
    else $error("wake outside hibernate");
  a_flags_reserved_zero: assert property (s_read(12'h024) |->
    (prdata & ~`TLF_FLAG_MASK) == 32'h0) else $error("reserved flag set");
  a_sample_upper_zero: assert property (s_read(12'h020) |->
    prdata[31:8] == 24'h0) else $error("sample upper bits");
  a_unmapped_error: assert property (acc && paddr > 12'h030 |-> pslverr)
    else $error("no error on unmapped");
  a_idle_no_error: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  a_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("ready late");
endmodule // tlf_checker
bind tlf_thermal_flags tlf_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .hibernate_state(hibernate_state), .thermal_wake(thermal_wake),
  .deep_sleep_thermal_wake_enable(deep_sleep_thermal_wake_enable));
`default_nettype wire

// >>> tlf_thermal_flags_test.sv
// Self-checking bench for the thermal limit flag block
`timescale 1ns/1ps
`default_nettype none
module tlf_thermal_flags_test;
  logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic        sv = 0, busy = 0, hib = 0, e;
  logic [7:0]  sval = 0;
  logic [5:0]  sup = 0;
  logic        lcl = 0, hcl = 0;
  wire         pready, pslverr, wake, wen;
  wire  [31:0] prdata;
  int          err_count = 0, comparisons = 0;
  // Short hold keeps the freeze window reachable in simulation
  tlf_thermal_flags #(.HOLD_CYCLES(20)) dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sample_valid(sv), .sample_value(sval),
    .thermal_measure_in_progress(busy), .supply_level(sup),
    .low_side_current_limit(lcl), .high_side_current_limit(hcl),
    .hibernate_state(hib), .thermal_wake(wake),
    .deep_sleep_thermal_wake_enable(wen));
  initial forever #20 ref_clk = ~ref_clk;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk) penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task automatic smp(input logic [7:0] v);
    sv <= 1;
    sval <= v;
    @(posedge ref_clk) sv <= 0;
    @(posedge ref_clk);
  endtask
  task automatic clr_wait();
    repeat (25) @(posedge ref_clk);
    apb(1, 12'h02c, 32'hffffffff);
  endtask
  task automatic t_reset();
    apb(0, 12'h01c, 0);
    cmp(rd, 32'h0000ff00);
    cmp({31'h0, wen}, 32'h0);
    apb(0, 12'h024, 0);
    cmp(rd, 32'h0);
    cmp({31'h0, e}, 32'h0);
    apb(0, 12'h040, 0);
    cmp({rd[30:0], e}, 32'h1);
  endtask
  task automatic t_setclr();
    apb(1, 12'h028, 32'h0000f0ff);
    apb(0, 12'h024, 0);
    cmp(rd, 32'h0000f0ff);
    apb(1, 12'h02c, 32'hffffffff);
    apb(0, 12'h024, 0);
    cmp(rd, 32'h0);
  endtask
  task automatic t_limits();
    apb(1, 12'h01c, 32'h00018010);
    cmp({31'h0, wen}, 32'h1);
    hib <= 1;
    smp(8'h80);
    apb(0, 12'h024, 0);
    cmp(rd, 32'ha0000000);
    cmp({31'h0, wake}, 32'h1);
    smp(8'h10);
    apb(0, 12'h020, 0);
    cmp(rd, 32'h80);
    hib <= 0;
    repeat (2) @(posedge ref_clk);
    cmp({31'h0, wake}, 32'h0);
    clr_wait();
    smp(8'h10);
    apb(0, 12'h024, 0);
    cmp(rd, 32'h60000000);
  endtask
  task automatic t_busy();
    clr_wait();
    busy <= 1;
    apb(1, 12'h01c, 32'h00002000);
    cmp({31'h0, wen}, 32'h0);
    smp(8'h30);
    apb(0, 12'h024, 0);
    cmp(rd, 32'h20000000);
    busy <= 0;
    clr_wait();
    smp(8'h30);
    apb(0, 12'h024, 0);
    cmp(rd, 32'ha0000000);
  endtask
  task automatic t_reread();
    logic [31:0] prev;
    int          n;
    prev = 32'hffffffff;
    n = 0;
    apb(0, 12'h020, 0);
    while (rd !== prev && n < 8) begin
      prev = rd;
      apb(0, 12'h020, 0);
      n++;
    end
    cmp(rd, prev);
    cmp(rd, 32'h30);
  endtask
  task automatic t_rdclr();
    apb(1, 12'h02c, 32'hffffffff);
    lcl <= 1;
    @(posedge ref_clk) lcl <= 0;
    hcl <= 1;
    @(posedge ref_clk) hcl <= 0;
    apb(1, 12'h030, 32'h1);
    apb(0, 12'h02c, 0);
    cmp(rd, 32'h00030000);
    apb(0, 12'h024, 0);
    cmp(rd, 32'h0);
    apb(1, 12'h028, 32'hffffffff);
    apb(0, 12'h024, 0);
    cmp(rd, 32'he35ff0ff);
    apb(1, 12'h030, 32'h0);
    apb(1, 12'h02c, 32'hffffffff);
  endtask
  task automatic t_supply();
    apb(1, 12'h02c, 32'hffffffff);
    sup <= 6'h01;
    repeat (6) @(posedge ref_clk);
    apb(0, 12'h024, 0);
    cmp(rd, 32'h2);
    sup <= 6'h00;
    repeat (6) @(posedge ref_clk);
    apb(0, 12'h024, 0);
    cmp(rd, 32'h3);
  endtask
  task automatic results();
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge ref_clk);
    err_count++;
    results();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_setclr();
    t_limits();
    t_busy();
    t_reread();
    t_rdclr();
    t_supply();
    results();
  end
endmodule // tlf_thermal_flags_test
`default_nettype wire
